// [pio_host_end.sv]
// Added by the designer: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - address, data and three control lines
// - data direction set before each transfer
// - write address: start plus write, clear
// - write data: start alone, clear
// - read address: start plus read, clear
// - release bus, wait, sample read data
// - wait covers device read latency
// - device oversamples control lines
// - device decodes cycles into transactions
// - collect read word before next; else overrun
module pio_host_end
    import pio_link_pkg::*;
#(
    parameter int WAIT_CYC = WAIT_CYC_DEF
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    pio_link_if.host         link,
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest
);
    typedef enum logic [8:0] {
        ST_IDLE   = 9'h001,
        ST_ADDR   = 9'h002,
        ST_ASTART = 9'h004,
        ST_ACLR   = 9'h008,
        ST_DATA   = 9'h010,
        ST_DSTART = 9'h020,
        ST_DCLR   = 9'h040,
        ST_TURN   = 9'h080,
        ST_WAIT   = 9'h100
    } state_type;

    localparam logic [CNT_W-1:0] PHASE_LAST = CNT_W'(PHASE_CYC - 1);
    localparam logic [CNT_W-1:0] WAIT_LAST = CNT_W'(WAIT_CYC - 1);

    state_type         state_q;
    logic [CNT_W-1:0]  cnt_q;
    logic              read_q;
    logic [31:0]       addr_q;
    logic [31:0]       wdata_q;
    logic [31:0]       rdata_q;
    logic              done_q;
    logic              overrun_q;
    logic              busy;
    logic              phase_end;
    logic              wait_end;
    logic              go;
    logic              rdata_taken;
    logic              rd_complete;
    logic              rd_ack_q;
    logic [31:0]       readback;
    logic [31:0]       cmd_word;
    logic [31:0]       be_mask;

    assign busy        = (state_q != ST_IDLE);
    assign phase_end   = (cnt_q == PHASE_LAST);
    assign wait_end    = (cnt_q == WAIT_LAST);
    assign be_mask     = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                          {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
    assign cmd_word    = i_avs_writedata & be_mask;
    assign go          = i_avs_write && (i_avs_address == REG_CMD) && cmd_word[CMD_GO] && !busy;
    assign rdata_taken = i_avs_read && (i_avs_address == REG_RDATA) && !rd_ack_q;
    assign rd_complete = (state_q == ST_WAIT) && wait_end;

    // waitrequest holds a write while the link is busy; a read waits one cycle for readdata
    assign o_avs_waitrequest = (i_avs_write && busy) || (i_avs_read && !rd_ack_q);

    // transfer sequencer
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= ST_IDLE;
            cnt_q   <= '0;
        end else begin
            cnt_q <= (phase_end || state_q == ST_IDLE) ? '0 : cnt_q + 1'b1;
            unique case (state_q)
                ST_IDLE: begin
                    if (go) begin
                        state_q <= ST_ADDR;
                    end
                end
                ST_ADDR: if (phase_end) begin
                    state_q <= ST_ASTART;
                end
                ST_ASTART: if (phase_end) begin
                    state_q <= ST_ACLR;
                end
                ST_ACLR: if (phase_end) begin
                    state_q <= read_q ? ST_TURN : ST_DATA;
                end
                ST_DATA: if (phase_end) begin
                    state_q <= ST_DSTART;
                end
                ST_DSTART: if (phase_end) begin
                    state_q <= ST_DCLR;
                end
                ST_DCLR: if (phase_end) begin
                    state_q <= ST_IDLE;
                end
                ST_TURN: if (phase_end) begin
                    state_q <= ST_WAIT;
                    cnt_q   <= '0;
                end
                ST_WAIT: begin
                    cnt_q <= wait_end ? '0 : cnt_q + 1'b1;
                    if (wait_end) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // software registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            read_q  <= 1'b0;
            addr_q  <= '0;
            wdata_q <= '0;
        end else if (i_avs_write && !busy) begin
            if (i_avs_address == REG_ADDR) begin
                addr_q <= (addr_q & ~be_mask) | cmd_word;
            end
            if (i_avs_address == REG_WDATA) begin
                wdata_q <= (wdata_q & ~be_mask) | cmd_word;
            end
            if (go) begin
                read_q <= cmd_word[CMD_READ];
            end
        end
    end

    // read capture with done and overrun flags; set wins over clear
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_q   <= '0;
            done_q    <= 1'b0;
            overrun_q <= 1'b0;
        end else begin
            if (rd_complete) begin
                rdata_q <= link.bus;
                done_q  <= 1'b1;
            end else if (rdata_taken) begin
                done_q <= 1'b0;
            end
            if (rd_complete && done_q && !rdata_taken) begin
                overrun_q <= 1'b1;
            end else if (go) begin
                overrun_q <= 1'b0;
            end
        end
    end

    // link pins
    always_comb begin
        link.ctrl           = '0;
        link.host_data      = addr_q;
        link.host_data_oe_n = 1'b0;
        unique case (state_q)
            ST_ASTART: begin
                link.ctrl[CTRL_START] = 1'b1;
                link.ctrl[CTRL_WR]    = !read_q;
                link.ctrl[CTRL_RD]    = read_q;
            end
            ST_DATA, ST_DCLR: begin
                link.host_data = wdata_q;
            end
            ST_DSTART: begin
                link.host_data        = wdata_q;
                link.ctrl[CTRL_START] = 1'b1;
            end
            ST_TURN, ST_WAIT: begin
                link.host_data_oe_n = 1'b1;
            end
            default: begin
            end
        endcase
    end

    // register readback
    always_comb begin
        readback = '0;
        unique case (i_avs_address)
            REG_CMD: begin
                readback[CMD_READ]    = read_q;
                readback[STS_BUSY]    = busy;
                readback[STS_DONE]    = done_q;
                readback[STS_OVERRUN] = overrun_q;
            end
            REG_ADDR:  readback = addr_q;
            REG_WDATA: readback = wdata_q;
            REG_RDATA: readback = rdata_q;
            default:   readback = '0;
        endcase
    end

    // one wait state per read so the registered readdata stands when waitrequest drops
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_avs_readdata <= '0;
            rd_ack_q       <= 1'b0;
        end else begin
            rd_ack_q <= i_avs_read && !rd_ack_q;
            if (i_avs_read && !rd_ack_q) begin
                o_avs_readdata <= readback;
            end
        end
    end
endmodule
`default_nettype wire

// [pio_link_pkg.sv]
package pio_link_pkg;
    localparam int DATA_W = 32;
    localparam int CTRL_W = 3;
    // control line positions on the control port
    localparam int CTRL_START = 0;
    localparam int CTRL_WR = 1;
    localparam int CTRL_RD = 2;
    // host register offsets (Avalon byte addresses)
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h4;
    localparam logic [3:0] REG_WDATA = 4'h8;
    localparam logic [3:0] REG_RDATA = 4'hC;
    // command register fields
    localparam int CMD_GO = 0;
    localparam int CMD_READ = 1;
    // status bits in command register readback
    localparam int STS_BUSY = 8;
    localparam int STS_DONE = 9;
    localparam int STS_OVERRUN = 10;
    // host cycle timing, each phase of the software routine
    localparam int PHASE_NS = 40;
    localparam int CLK_NS = 10;
    localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;
    // read response wait, 25 host bus cycles
    localparam int WAIT_CYC_DEF = 25;
    // device-side control line synchroniser delay in cycles, taken off the answer window
    localparam int STABLE_CYC = 2;
    localparam int CNT_W = 8;
endpackage

// [pio_link_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface pio_link_if;
    import pio_link_pkg::*;
    logic [DATA_W-1:0] host_data;
    logic              host_data_oe_n;
    logic [DATA_W-1:0] fpga_data;
    logic              fpga_data_oe_n;
    logic [CTRL_W-1:0] ctrl;
    logic [DATA_W-1:0] bus;
    // resolved wire level of the shared data bus
    assign bus = !host_data_oe_n ? host_data : (!fpga_data_oe_n ? fpga_data : '0);
    modport host (output host_data, output host_data_oe_n, output ctrl, input bus);
    modport fpga (output fpga_data, output fpga_data_oe_n, input ctrl, input bus);
endinterface
`default_nettype wire

// [ctrl_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module ctrl_sync #(
    parameter int W = 3
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    // two-stage oversampler for asynchronous control lines
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end
    assign o_sync = sync_q;
endmodule
`default_nettype wire

// [pio_fpga_end.sv]
`timescale 1ns/100ps
`default_nettype none
module pio_fpga_end
    import pio_link_pkg::*;
#(
    parameter int ANSWER_CYC = WAIT_CYC_DEF + PHASE_CYC - STABLE_CYC
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    pio_link_if.fpga               link,
    input  wire logic [DATA_W-1:0] i_rd_data,
    output logic                   o_wr_valid,
    output logic      [DATA_W-1:0] o_wr_addr,
    output logic      [DATA_W-1:0] o_wr_data,
    output logic                   o_rd_req,
    output logic      [DATA_W-1:0] o_rd_addr
);
    // turnaround matches the host's release phase; the answer window ends as the host samples
    localparam logic [CNT_W-1:0] TURN_LAST = CNT_W'(PHASE_CYC - 1);
    localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(ANSWER_CYC - 1);

    logic [CTRL_W-1:0] ctrl_s;
    logic [CTRL_W-1:0] ctrl_q;
    logic [DATA_W-1:0] bus_q;
    logic [DATA_W-1:0] bus_qq;
    logic              write_pending_q;
    logic              read_pending_q;
    logic [DATA_W-1:0] drive_q;
    logic              drive_oe_n_q;
    logic              start_rise;
    logic [CNT_W-1:0]  drive_cnt_q;
    logic              turn_done;
    logic              hold_done;

    ctrl_sync #(.W(CTRL_W)) u_sync (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_async (link.ctrl),
        .o_sync  (ctrl_s)
    );

    // bus delayed to line up with the synchronised control lines
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            bus_q  <= '0;
            bus_qq <= '0;
            ctrl_q <= '0;
        end else begin
            bus_q  <= link.bus;
            bus_qq <= bus_q;
            ctrl_q <= ctrl_s;
        end
    end

    assign start_rise = ctrl_s[CTRL_START] && !ctrl_q[CTRL_START];
    assign turn_done  = (drive_cnt_q == TURN_LAST);
    assign hold_done  = (drive_cnt_q == HOLD_LAST);

    // decode address and data cycles, reads and writes
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            write_pending_q <= 1'b0;
            read_pending_q  <= 1'b0;
            o_wr_valid      <= 1'b0;
            o_wr_addr       <= '0;
            o_wr_data       <= '0;
            o_rd_req        <= 1'b0;
            o_rd_addr       <= '0;
        end else begin
            o_wr_valid <= 1'b0;
            o_rd_req   <= 1'b0;
            if (start_rise) begin
                if (ctrl_s[CTRL_WR]) begin
                    o_wr_addr       <= bus_qq;
                    write_pending_q <= 1'b1;
                    read_pending_q  <= 1'b0;
                end else if (ctrl_s[CTRL_RD]) begin
                    o_rd_addr       <= bus_qq;
                    o_rd_req        <= 1'b1;
                    read_pending_q  <= 1'b1;
                    write_pending_q <= 1'b0;
                end else if (write_pending_q) begin
                    o_wr_data       <= bus_qq;
                    o_wr_valid      <= 1'b1;
                    write_pending_q <= 1'b0;
                end
            end else if (read_pending_q && ctrl_s == '0 && turn_done) begin
                read_pending_q <= 1'b0;
            end
        end
    end

    // wait out the host's turnaround, then drive read data for a bounded window;
    // the host gives no release signal, so the window must match its wait setting
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            drive_q      <= '0;
            drive_oe_n_q <= 1'b1;
            drive_cnt_q  <= '0;
        end else if (start_rise) begin
            drive_oe_n_q <= 1'b1;
            drive_cnt_q  <= '0;
        end else if (read_pending_q && ctrl_s == '0) begin
            drive_cnt_q <= turn_done ? '0 : drive_cnt_q + 1'b1;
            if (turn_done) begin
                drive_q      <= i_rd_data;
                drive_oe_n_q <= 1'b0;
            end
        end else if (!drive_oe_n_q) begin
            drive_cnt_q <= hold_done ? '0 : drive_cnt_q + 1'b1;
            if (hold_done) begin
                drive_oe_n_q <= 1'b1;
            end
        end
    end

    assign link.fpga_data      = drive_q;
    assign link.fpga_data_oe_n = drive_oe_n_q;
endmodule
`default_nettype wire

// [pio_link_properties.sv]
`timescale 1ns/100ps
`default_nettype none
module pio_link_properties
    import pio_link_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic [DATA_W-1:0] host_data,
    input  wire logic              host_data_oe_n,
    input  wire logic              fpga_data_oe_n,
    input  wire logic [CTRL_W-1:0] ctrl
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // bus ownership and control codes
    chk_no_bus_fight: assert property (host_data_oe_n || fpga_data_oe_n)
        else $error("both ends drive the data bus");
    chk_ctrl_codes: assert property (ctrl inside {3'h0, 3'h1, 3'h3, 3'h5})
        else $error("illegal control code");
    chk_phase_hold: assert property ($rose(ctrl[CTRL_START]) |=> $stable(ctrl) [*3])
        else $error("control phase shorter than four cycles");
    chk_clear_all: assert property ($fell(ctrl[CTRL_START]) |-> ctrl == '0)
        else $error("control lines not cleared together");
    chk_data_held: assert property (ctrl[CTRL_START] |-> !host_data_oe_n && $stable(host_data))
        else $error("host data not driven steady under start");
    // read turnaround and answer
    chk_host_turn: assert property ($fell(ctrl[CTRL_RD]) |-> ##[1:8] host_data_oe_n)
        else $error("host did not release bus after read address");
    chk_host_quiet: assert property (host_data_oe_n |-> ctrl == '0)
        else $error("control active while host listens");
    chk_fpga_reply: assert property ($fell(ctrl[CTRL_RD]) |-> ##[1:40] !fpga_data_oe_n)
        else $error("device did not answer read");
    chk_fpga_idle_wr: assert property (ctrl[CTRL_WR] |-> fpga_data_oe_n)
        else $error("device drives bus during write");
    chk_fpga_release: assert property ($fell(fpga_data_oe_n) |-> ##[1:40] fpga_data_oe_n)
        else $error("device held the data bus too long");
    // main scenarios
    cov_write: cover property (ctrl == 3'h3);
    cov_read: cover property (ctrl == 3'h5);
    cov_answer: cover property (!fpga_data_oe_n);
endmodule
`default_nettype wire

// [gpio_fpga_parallel_handshake_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module gpio_fpga_parallel_handshake_bench;
    import pio_link_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [3:0]  av_addr = 4'h0;
    logic        av_read = 1'b0;
    logic        av_write = 1'b0;
    logic [31:0] av_wdata = 32'h0;
    logic [3:0]  av_be = 4'hF;
    logic [31:0] av_rdata;
    logic        av_wait;
    logic [31:0] rd_data = 32'h0;
    logic        wr_valid;
    logic [31:0] wr_addr;
    logic [31:0] wr_data;
    logic        rd_req;
    logic [31:0] rd_addr;
    logic [31:0] v;
    logic [31:0] wa [0:3];
    logic [31:0] wd [0:3];
    int          wr_cnt = 0;
    int          rd_cnt = 0;
    int          cyc = 0;
    int          error_cnt = 0;
    int          n_checks = 0;
    localparam int HOST_WAIT = 8;
    always #5 i_clk = ~i_clk;
    // both ends joined across the link
    pio_link_if u_pio_link_if ();
    pio_host_end #(.WAIT_CYC(HOST_WAIT)) u_pio_host_end (.i_clk(i_clk), .i_rst(i_rst), .link(u_pio_link_if.host),
        .i_avs_address(av_addr), .i_avs_read(av_read), .i_avs_write(av_write), .i_avs_writedata(av_wdata),
        .i_avs_byteenable(av_be), .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait));
    pio_fpga_end #(.ANSWER_CYC(HOST_WAIT + PHASE_CYC - STABLE_CYC)) u_pio_fpga_end (.i_clk(i_clk), .i_rst(i_rst),
        .link(u_pio_link_if.fpga), .i_rd_data(rd_data),
        .o_wr_valid(wr_valid), .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_rd_req(rd_req), .o_rd_addr(rd_addr));
    pio_link_properties u_pio_link_properties (.i_clk(i_clk), .i_rst(i_rst),
        .host_data(u_pio_link_if.host_data), .host_data_oe_n(u_pio_link_if.host_data_oe_n),
        .fpga_data_oe_n(u_pio_link_if.fpga_data_oe_n), .ctrl(u_pio_link_if.ctrl));
    // log delivered words, count requests, cut hangs short
    always @(posedge i_clk) begin
        if (wr_valid === 1'b1 && wr_cnt < 4) begin
            wa[wr_cnt] = wr_addr;
            wd[wr_cnt] = wr_data;
        end
        if (wr_valid === 1'b1)
            wr_cnt++;
        if (rd_req === 1'b1)
            rd_cnt++;
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        av_addr <= a;
        av_wdata <= d;
        av_be <= be;
        av_write <= 1'b1;
        do @(posedge i_clk); while (av_wait !== 1'b0);
        av_write <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        av_addr <= a;
        av_read <= 1'b1;
        do @(posedge i_clk); while (av_wait !== 1'b0);
        d = av_rdata;
        av_read <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic wait_idle(output logic [31:0] s);
        s = '1;
        for (int k = 0; k < 100 && s[STS_BUSY] !== 1'b0; k++)
            rd(REG_CMD, s);
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // reset, then writes, reads and an overrun
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        rd(REG_CMD, v);
        check(v, 32'h0);
        rd(4'h2, v);
        check(v, 32'h0);
        wr(REG_ADDR, 32'h1234_5678, 4'hF);
        wr(REG_WDATA, 32'h1122_3344, 4'hF);
        wr(REG_WDATA, 32'hAAAA_BBBB, 4'h3);
        rd(REG_WDATA, v);
        check(v, 32'h1122_BBBB);
        rd(REG_ADDR, v);
        check(v, 32'h1234_5678);
        wr(REG_CMD, 32'h1, 4'hF);
        wr(REG_ADDR, 32'hFFFF_FFFC, 4'hF);
        wr(REG_WDATA, 32'h0, 4'hF);
        wr(REG_CMD, 32'h1, 4'hF);
        wait_idle(v);
        check(wr_cnt, 2);
        check(wa[0], 32'h1234_5678);
        check(wd[0], 32'h1122_BBBB);
        check(wa[1], 32'hFFFF_FFFC);
        check(wd[1], 32'h0);
        check(rd_cnt, 0);
        rd_data <= 32'hA5C3_0F96;
        wr(REG_ADDR, 32'h0000_0040, 4'hF);
        wr(REG_CMD, 32'h3, 4'hF);
        wait_idle(v);
        check(v & 32'h0000_0700, 32'h0000_0200);
        check(rd_cnt, 1);
        check(rd_addr, 32'h0000_0040);
        rd(REG_RDATA, v);
        check(v, 32'hA5C3_0F96);
        rd(REG_CMD, v);
        check(v & 32'h0000_0700, 32'h0);
        rd_data <= 32'h5A5A_0001;
        wr(REG_CMD, 32'h3, 4'hF);
        wait_idle(v);
        rd_data <= 32'h0F0F_0002;
        wr(REG_CMD, 32'h3, 4'hF);
        wait_idle(v);
        check(v & 32'h0000_0700, 32'h0000_0600);
        rd(REG_RDATA, v);
        check(v, 32'h0F0F_0002);
        wr(REG_CMD, 32'h1, 4'hF);
        wait_idle(v);
        check(v & 32'h0000_0400, 32'h0);
        check(wr_cnt, 3);
        check(rd_cnt, 3);
        tally_and_finish();
    end
endmodule
`default_nettype wire
